/* pin_mux_pkg.sv */
// constants, register layout and carrier types for the port pin function mux
package pin_mux_pkg;

    // ****************************************
    // register bus
    // ****************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    // port index sits in addr[5:3], field in addr[2:0]
    localparam int NPORT = 6;
    localparam logic [2:0] PORT_T = 3'h0;
    localparam logic [2:0] PORT_S = 3'h1;
    localparam logic [2:0] PORT_M = 3'h2;
    localparam logic [2:0] PORT_P = 3'h3;
    localparam logic [2:0] PORT_AD = 3'h4;
    localparam logic [2:0] PORT_J = 3'h5;
    localparam logic [2:0] FLD_DATA = 3'h0;
    localparam logic [2:0] FLD_INPUT = 3'h1;
    localparam logic [2:0] FLD_DIR = 3'h2;
    localparam logic [2:0] FLD_RDRV = 3'h3;
    localparam logic [2:0] FLD_PULL_EN = 3'h4;
    localparam logic [2:0] FLD_PULL_SEL = 3'h5;
    localparam logic [2:0] FLD_AUX = 3'h6;
    localparam logic [2:0] FLD_FLAG = 3'h7;
    localparam logic [ADDR_W-1:0] ROUTE_OFS = 6'h07;

    // ****************************************
    // port layout
    // ****************************************
    localparam logic [7:0] PORT_MASK [NPORT] = '{8'hff, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hc0};
    localparam logic [NPORT-1:0] OD_PORTS = 6'h06;
    localparam logic [NPORT-1:0] IRQ_PORTS = 6'h28;
    localparam int PWM_N = 6;
    localparam int PWM_T_N = 5;
    localparam int TIM_N = 8;
    localparam int SPI_N = 4;
    localparam int SPI_PIN_BASE = 2;
    localparam int SCI_TX_BIT = 1;
    localparam int SCI_RX_BIT = 0;
    localparam int CAN_TX_BIT = 1;
    localparam int CAN_RX_BIT = 0;
    localparam int IRQ_W = 16;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [PWM_T_N-1:0] ROUTE_RST = 5'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 8;
    localparam int FILT_TICK_NS = 80;
    localparam int FILT_TICK_CYC = (FILT_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_SAMPLES = 4;
    localparam int TICK_W = 4;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] rdrv;
        logic [7:0] pull_en;
        logic [7:0] pull_sel;
        logic [7:0] aux;
        logic [7:0] flag;
    } port_cfg_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] rdrv;
        logic [7:0] pull_en;
        logic [7:0] pull_dn;
    } pad_ctl_t;

    // spi lines ordered [3]=sck [2]=mosi [1]=ss [0]=miso
    typedef struct packed {
        logic [PWM_N-1:0] pwm_out;
        logic [PWM_N-1:0] pwm_en;
        logic [TIM_N-1:0] timer_channel_io;
        logic [TIM_N-1:0] tim_en;
        logic [TIM_N-1:0] tim_oe;
        logic sci_txd;
        logic sci_tx_en;
        logic sci_rx_en;
        logic spi_en;
        logic [SPI_N-1:0] spi_o;
        logic [SPI_N-1:0] spi_oe;
        logic can_en;
        logic can_tx_line;
    } periph_out_t;

    typedef struct packed {
        logic [TIM_N-1:0] tim_in;
        logic sci_rxd;
        logic [SPI_N-1:0] spi_i;
        logic can_rx_line;
    } periph_in_t;

endpackage

/* pin_event_filter.sv */
// glitch filter for pin interrupt inputs, sampled on a slow tick
`timescale 1ns/1ns
module pin_event_filter
    import pin_mux_pkg::*;
#(
    parameter int WIDTH = IRQ_W,
    parameter int SAMPLES = FILT_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sample enable
    input wire logic tick,
    // levels
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);

    localparam int CW = $clog2(SAMPLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

    logic [WIDTH-1:0][CW-1:0] cnt_ff;
    logic [WIDTH-1:0][CW-1:0] nxt_cnt;
    logic [WIDTH-1:0] clean_ff;
    logic [WIDTH-1:0] nxt_clean;

    // a new level must hold for SAMPLES ticks in a row before it is taken
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_clean = clean_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (raw[i] == clean_ff[i]) begin
                nxt_cnt[i] = '0;
            end else if (tick) begin
                if (cnt_ff[i] == LAST) begin
                    nxt_clean[i] = raw[i];
                    nxt_cnt[i] = '0;
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            clean_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            clean_ff <= nxt_clean;
        end
    end

    assign clean = clean_ff;

endmodule

/* port_pin_function_mux.sv */
// pin function mux: peripheral ownership, pad control, pin interrupts
//
// How it works
// - a shared pin goes to the highest priority enabled function, gpio last
// - pwm channels 4..0 reach port t only when their route bit is set
// - port t pin carries timer channel of same index unless a routed pwm claims it
// - port s bit 1 serial transmit, bit 0 receive; bits 3,2 gpio only
// - port m pins 5..2 carry spi sck,mosi,ss,miso; pins 1,0 can tx,rx
// - port p carries enabled pwm outputs; other pins are gpio with interrupt
// - port j bits 7,6 are gpio with interrupt capability
// - every pin has direction, reduced drive and pull enable with up/down select
// - port p and j pins have own flag and enable; irq needs both set
// - ports s and m may run open drain: drive low only, else release
// - pin interrupt inputs are filtered so short glitches set no flag
// - after reset port t is gpio with no peripheral driving it
// - a pwm channel on both port t and port p drives both pins
// - analog port pin with digital input disabled reads 1 in the readback
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module port_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int TICK_CYC = FILT_TICK_CYC,
    parameter int SAMPLES = FILT_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // pads
    input wire logic [NPORT-1:0][7:0] pin_in,
    output pad_ctl_t [NPORT-1:0] pad,
    // peripherals
    input wire periph_out_t periph_out,
    output periph_in_t periph_in,
    // analog converter
    input wire logic [7:0] adc_digital_input_enable,
    output logic [7:0] adc_port_readback,
    // interrupt
    output logic irq
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic is_route(input logic [ADDR_W-1:0] a);
        return a == ROUTE_OFS;
    endfunction

    // a field exists only where the port has it
    function automatic logic fld_ok(input logic [2:0] p, input logic [2:0] f);
        logic ok;
        ok = 1'b0;
        if (p < 3'(NPORT)) begin
            unique case (f)
                FLD_AUX: ok = OD_PORTS[p] | IRQ_PORTS[p];
                FLD_FLAG: ok = IRQ_PORTS[p];
                default: ok = 1'b1;
            endcase
        end
        return ok;
    endfunction

    // ****************************************
    // registers and interrupt flags
    // ****************************************
    port_cfg_t cfg_ff [NPORT];
    port_cfg_t nxt_cfg [NPORT];
    logic [PWM_T_N-1:0] pwm_route_select_ff;
    logic [PWM_T_N-1:0] nxt_pwm_route_select;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic irq_ff;
    logic nxt_irq;
    logic [2:0] a_port;
    logic [2:0] a_fld;
    logic [NPORT-1:0][7:0] pin_event;

    assign a_port = addr[5:3];
    assign a_fld = addr[2:0];

    always_comb begin
        logic [7:0] m;
        logic [7:0] pend;
        m = '0;
        pend = '0;
        nxt_pwm_route_select = pwm_route_select_ff;
        nxt_rdata = '0;
        nxt_irq = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            nxt_cfg[p] = cfg_ff[p];
        end
        if (wr && is_route(addr)) begin
            nxt_pwm_route_select = wdata[PWM_T_N-1:0];
        end else if (wr && fld_ok(a_port, a_fld)) begin
            m = PORT_MASK[a_port];
            unique case (a_fld)
                FLD_DATA: nxt_cfg[a_port].data = wdata & m;
                FLD_DIR: nxt_cfg[a_port].dir = wdata & m;
                FLD_RDRV: nxt_cfg[a_port].rdrv = wdata & m;
                FLD_PULL_EN: nxt_cfg[a_port].pull_en = wdata & m;
                FLD_PULL_SEL: nxt_cfg[a_port].pull_sel = wdata & m;
                FLD_AUX: nxt_cfg[a_port].aux = wdata & m;
                FLD_FLAG: nxt_cfg[a_port].flag = cfg_ff[a_port].flag & ~wdata;
                default: ;
            endcase
        end
        // a pin event in the clearing cycle still sets its flag
        for (int p = 0; p < NPORT; p++) begin
            if (IRQ_PORTS[p]) begin
                nxt_cfg[p].flag = nxt_cfg[p].flag | (pin_event[p] & PORT_MASK[p]);
                pend = pend | (cfg_ff[p].flag & cfg_ff[p].aux);
            end
        end
        nxt_irq = |pend;
        if (rd && is_route(addr)) begin
            nxt_rdata = 8'(pwm_route_select_ff);
        end else if (rd && fld_ok(a_port, a_fld)) begin
            unique case (a_fld)
                // output bits read the latch, input bits read the pin
                FLD_DATA: nxt_rdata = (cfg_ff[a_port].data & cfg_ff[a_port].dir)
                    | (pin_in[a_port] & ~cfg_ff[a_port].dir);
                FLD_INPUT: nxt_rdata = pin_in[a_port];
                FLD_DIR: nxt_rdata = cfg_ff[a_port].dir;
                FLD_RDRV: nxt_rdata = cfg_ff[a_port].rdrv;
                FLD_PULL_EN: nxt_rdata = cfg_ff[a_port].pull_en;
                FLD_PULL_SEL: nxt_rdata = cfg_ff[a_port].pull_sel;
                FLD_AUX: nxt_rdata = cfg_ff[a_port].aux;
                FLD_FLAG: nxt_rdata = cfg_ff[a_port].flag;
                default: nxt_rdata = '0;
            endcase
            nxt_rdata = nxt_rdata & PORT_MASK[a_port];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < NPORT; p++) begin
                cfg_ff[p] <= '{CFG_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST};
            end
            pwm_route_select_ff <= ROUTE_RST;
            rdata_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                cfg_ff[p] <= nxt_cfg[p];
            end
            pwm_route_select_ff <= nxt_pwm_route_select;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
        end
    end

    // ****************************************
    // pin event filter and edge detect
    // ****************************************
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] nxt_tick_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [IRQ_W-1:0] filt_raw;
    logic [IRQ_W-1:0] filt_clean;
    logic [IRQ_W-1:0] clean_q_ff;

    assign filt_raw = {pin_in[PORT_J], pin_in[PORT_P]};

    always_comb begin
        nxt_tick = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + TICK_W'(1);
        if (tick_cnt_ff == TICK_W'(TICK_CYC - 1)) begin
            nxt_tick_cnt = '0;
            nxt_tick = 1'b1;
        end
    end

    // edge sense follows the pull select: pull-down senses rising, pull-up falling
    always_comb begin
        logic [IRQ_W-1:0] rise;
        logic [IRQ_W-1:0] fall;
        logic [IRQ_W-1:0] sel;
        rise = filt_clean & ~clean_q_ff;
        fall = ~filt_clean & clean_q_ff;
        sel = {cfg_ff[PORT_J].pull_sel, cfg_ff[PORT_P].pull_sel};
        pin_event = '0;
        pin_event[PORT_P] = 8'((rise & sel) | (fall & ~sel));
        pin_event[PORT_J] = 8'(((rise & sel) | (fall & ~sel)) >> 8);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
            clean_q_ff <= '0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
            clean_q_ff <= filt_clean;
        end
    end

    pin_event_filter #(
        .WIDTH(IRQ_W),
        .SAMPLES(SAMPLES)
    ) u_filter (
        .clk(clk),
        .nrst(nrst),
        .tick(tick_ff),
        .raw(filt_raw),
        .clean(filt_clean)
    );

    // ****************************************
    // function selection and pad control
    // ****************************************
    pad_ctl_t [NPORT-1:0] pad_ff;
    pad_ctl_t [NPORT-1:0] nxt_pad;
    periph_in_t periph_in_ff;
    periph_in_t nxt_periph_in;
    logic [7:0] adc_port_readback_ff;
    logic [7:0] nxt_adc_port_readback;

    always_comb begin
        logic [NPORT-1:0][7:0] own;
        logic [NPORT-1:0][7:0] pout;
        logic [NPORT-1:0][7:0] poe;
        logic [7:0] drive;
        logic [7:0] val;
        logic [7:0] od;
        own = '0;
        pout = '0;
        poe = '0;
        drive = '0;
        val = '0;
        od = '0;
        // lowest priority first, so a later claim overrides an earlier one
        for (int i = 0; i < TIM_N; i++) begin
            if (periph_out.tim_en[i]) begin
                own[PORT_T][i] = 1'b1;
                pout[PORT_T][i] = periph_out.timer_channel_io[i];
                poe[PORT_T][i] = periph_out.tim_oe[i];
            end
        end
        for (int i = 0; i < PWM_T_N; i++) begin
            if (pwm_route_select_ff[i]) begin
                own[PORT_T][i] = 1'b1;
                pout[PORT_T][i] = periph_out.pwm_out[i];
                poe[PORT_T][i] = 1'b1;
            end
        end
        for (int i = 0; i < PWM_N; i++) begin
            if (periph_out.pwm_en[i]) begin
                own[PORT_P][i] = 1'b1;
                pout[PORT_P][i] = periph_out.pwm_out[i];
                poe[PORT_P][i] = 1'b1;
            end
        end
        if (periph_out.sci_tx_en) begin
            own[PORT_S][SCI_TX_BIT] = 1'b1;
            pout[PORT_S][SCI_TX_BIT] = periph_out.sci_txd;
            poe[PORT_S][SCI_TX_BIT] = 1'b1;
        end
        own[PORT_S][SCI_RX_BIT] = periph_out.sci_rx_en;
        if (periph_out.spi_en) begin
            for (int i = 0; i < SPI_N; i++) begin
                own[PORT_M][SPI_PIN_BASE+i] = 1'b1;
                pout[PORT_M][SPI_PIN_BASE+i] = periph_out.spi_o[i];
                poe[PORT_M][SPI_PIN_BASE+i] = periph_out.spi_oe[i];
            end
        end
        if (periph_out.can_en) begin
            own[PORT_M][CAN_TX_BIT] = 1'b1;
            pout[PORT_M][CAN_TX_BIT] = periph_out.can_tx_line;
            poe[PORT_M][CAN_TX_BIT] = 1'b1;
            own[PORT_M][CAN_RX_BIT] = 1'b1;
        end
        for (int p = 0; p < NPORT; p++) begin
            drive = ((own[p] & poe[p]) | (~own[p] & cfg_ff[p].dir)) & PORT_MASK[p];
            val = (own[p] & pout[p]) | (~own[p] & cfg_ff[p].data);
            od = OD_PORTS[p] ? cfg_ff[p].aux : 8'h00;
            // open drain only ever pulls low; high is left to the wire
            nxt_pad[p].out = val & drive & ~od;
            nxt_pad[p].oe_n = ~(drive & (~od | ~val));
            nxt_pad[p].rdrv = cfg_ff[p].rdrv & PORT_MASK[p];
            // a pull fights the driver, so it is dropped while driving
            nxt_pad[p].pull_en = cfg_ff[p].pull_en & PORT_MASK[p] & ~drive;
            nxt_pad[p].pull_dn = cfg_ff[p].pull_sel & PORT_MASK[p];
        end
        nxt_periph_in.tim_in = pin_in[PORT_T];
        nxt_periph_in.sci_rxd = pin_in[PORT_S][SCI_RX_BIT];
        nxt_periph_in.spi_i = pin_in[PORT_M][SPI_PIN_BASE +: SPI_N];
        nxt_periph_in.can_rx_line = pin_in[PORT_M][CAN_RX_BIT];
        nxt_adc_port_readback = pin_in[PORT_AD] | ~adc_digital_input_enable;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < NPORT; p++) begin
                pad_ff[p] <= '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
            end
            periph_in_ff <= '0;
            adc_port_readback_ff <= 8'hff;
        end else begin
            pad_ff <= nxt_pad;
            periph_in_ff <= nxt_periph_in;
            adc_port_readback_ff <= nxt_adc_port_readback;
        end
    end

    assign pad = pad_ff;
    assign periph_in = periph_in_ff;
    assign adc_port_readback = adc_port_readback_ff;
    assign rdata = rdata_ff;
    assign irq = irq_ff;

endmodule

/* pin_mux_chk.sv */
// assertion checker for the port pin function mux
`timescale 1ns/1ns
module pin_mux_chk
    import pin_mux_pkg::*;
#(
    parameter int TICK_CYC = FILT_TICK_CYC,
    parameter int SAMPLES = FILT_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    // pads
    input wire logic [NPORT-1:0][7:0] pin_in,
    input wire pad_ctl_t [NPORT-1:0] pad,
    // peripherals
    input wire periph_out_t periph_out,
    input wire periph_in_t periph_in,
    // analog and interrupt
    input wire logic [7:0] adc_digital_input_enable,
    input wire logic [7:0] adc_port_readback,
    input wire logic irq
);
    // ****************************************
    // helpers
    // ****************************************
    logic pull_clash;
    always_comb begin
        pull_clash = 1'b0;
        for (int i = 0; i < NPORT; i++) begin
            pull_clash = pull_clash | (|(pad[i].pull_en & ~pad[i].oe_n));
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ****************************************
    // properties
    // ****************************************
    property p_adc_rb;
        1 |=> adc_port_readback == ($past(pin_in[PORT_AD]) | ~$past(adc_digital_input_enable));
    endproperty
    a_adc_rb: assert property (p_adc_rb) else $error("analog readback wrong");
    property p_in_copy;
        1 |=> periph_in.tim_in == $past(pin_in[PORT_T])
            && periph_in.sci_rxd == $past(pin_in[PORT_S][SCI_RX_BIT])
            && periph_in.spi_i == $past(pin_in[PORT_M][SPI_PIN_BASE +: SPI_N]);
    endproperty
    a_in_copy: assert property (p_in_copy) else $error("pin copy to peripheral wrong");
    property p_pwm_p;
        1 |=> ((pad[PORT_P].oe_n[5:0] | (pad[PORT_P].out[5:0] ^ $past(periph_out.pwm_out)))
            & $past(periph_out.pwm_en)) == 6'h00;
    endproperty
    a_pwm_p: assert property (p_pwm_p) else $error("pwm missing on port p");
    property p_spi;
        $past(periph_out.spi_en) |-> ((pad[PORT_M].oe_n[5:2] | pad[PORT_M].out[5:2])
            & $past(periph_out.spi_oe) & ~$past(periph_out.spi_o)) == 4'h0;
    endproperty
    a_spi: assert property (p_spi) else $error("spi low not driven on port m");
    property p_can;
        periph_out.can_en && !periph_out.can_tx_line |=> !pad[PORT_M].oe_n[1] && !pad[PORT_M].out[1];
    endproperty
    a_can: assert property (p_can) else $error("can transmit low not driven");
    property p_sci;
        periph_out.sci_tx_en && !periph_out.sci_txd |=> !pad[PORT_S].oe_n[1] && !pad[PORT_S].out[1];
    endproperty
    a_sci: assert property (p_sci) else $error("serial transmit low not driven");
    property p_pull;
        pull_clash == 1'b0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull left on a driven pad");
    property p_rst_t;
        $rose(nrst) |-> pad[PORT_T].oe_n == 8'hff && irq == 1'b0;
    endproperty
    a_rst_t: assert property (p_rst_t) else $error("port t driven after reset");
    c_irq: cover property ($rose(irq));
    c_read: cover property (rd ##1 rdata != 8'h00);
    c_spi: cover property (periph_out.spi_en && !pad[PORT_M].oe_n[5]);
endmodule

/* pad_world.sv */
// far side model: pads resolved against board drivers and pulls
`timescale 1ns/1ns
module pad_world
    import pin_mux_pkg::*;
(
    // pads from the mux
    input wire pad_ctl_t [NPORT-1:0] pad,
    // levels the board puts on released, unpulled pins
    input wire logic [NPORT-1:0][7:0] ext,
    // resolved levels
    output logic [NPORT-1:0][7:0] pin_in
);
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!pad[p].oe_n[b]) begin
                    pin_in[p][b] = pad[p].out[b];
                end else if (pad[p].pull_en[b]) begin
                    pin_in[p][b] = ~pad[p].pull_dn[b];
                end else begin
                    // released line follows the board, so wired-and works
                    pin_in[p][b] = ext[p][b];
                end
            end
        end
    end
endmodule

/* testbench.sv */
// self-checking testbench for the port pin function mux
`timescale 1ns/1ns
module testbench
    import pin_mux_pkg::*;
;
    logic clk, nrst, wr, rd, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [NPORT-1:0][7:0] pin_in, ext, ev;
    pad_ctl_t [NPORT-1:0] pad;
    periph_out_t periph_out, po;
    periph_in_t periph_in;
    logic [7:0] adc_en, adc_rb;
    int error_cnt, n_checks, cyc_cnt;

    // short filter keeps the interrupt waits small
    port_pin_function_mux #(.TICK_CYC(2), .SAMPLES(2)) dut (.clk(clk), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
        .pad(pad), .periph_out(periph_out), .periph_in(periph_in),
        .adc_digital_input_enable(adc_en), .adc_port_readback(adc_rb), .irq(irq));
    pad_world board (.pad(pad), .ext(ext), .pin_in(pin_in));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic apply(input int n);
        @(posedge clk);
        periph_out <= po;
        ext <= ev;
        settle(n);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        po = '0;
        ev = '0;
        periph_out = '0;
        ext = '0;
        adc_en = 8'h0f;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        chk(pad[PORT_T].oe_n, 8'hff);
        for (int p = 0; p < NPORT; p++) begin
            for (int f = 2; f < 6; f++) begin
                rchk({p[2:0], f[2:0]}, 8'h00);
                wreg({p[2:0], f[2:0]}, 8'hff);
                rchk({p[2:0], f[2:0]}, PORT_MASK[p]);
            end
        end
        settle(2);
        chk(pad[PORT_T].rdrv, 8'hff);
        chk(pad[PORT_T].pull_en, 8'h00);
        chk(pad[PORT_T].pull_dn, 8'hff);
        for (int p = 0; p < NPORT; p++) begin
            for (int f = 2; f < 6; f++) begin
                wreg({p[2:0], f[2:0]}, 8'h00);
            end
        end
        rchk(6'h06, 8'h00);
        wreg(ROUTE_OFS, 8'hff);
        rchk(ROUTE_OFS, 8'h1f);
        wreg(ROUTE_OFS, 8'h00);
        $display("register test done");
        // timer, then routed pwm on port t
        po.tim_en = 8'h08;
        po.tim_oe = 8'h08;
        po.timer_channel_io = 8'h08;
        apply(2);
        chk(pad[PORT_T].out & ~pad[PORT_T].oe_n, 8'h08);
        po.pwm_en = 6'h08;
        apply(2);
        chk(pad[PORT_T].out & ~pad[PORT_T].oe_n, 8'h08);
        chk(pad[PORT_P].oe_n & 8'h08, 8'h00);
        wreg(ROUTE_OFS, 8'h08);
        settle(2);
        chk(pad[PORT_T].out & 8'h08, 8'h00);
        po.pwm_out = 6'h08;
        po.timer_channel_io = 8'h00;
        apply(2);
        chk(pad[PORT_T].out & pad[PORT_P].out & 8'h08, 8'h08);
        po = '0;
        apply(2);
        chk(pad[PORT_T].oe_n, 8'hf7);
        wreg(ROUTE_OFS, 8'h00);
        settle(2);
        chk(pad[PORT_T].oe_n, 8'hff);
        $display("port t test done");
        // serial transmit, open drain release
        po.sci_tx_en = 1'b1;
        apply(2);
        chk(pad[PORT_S].oe_n & 8'h02, 8'h00);
        wreg(6'h0e, 8'h02);
        po.sci_txd = 1'b1;
        apply(2);
        chk(pad[PORT_S].oe_n & 8'h02, 8'h02);
        // spi and can override gpio on port m
        wreg(6'h12, 8'h3f);
        po.spi_en = 1'b1;
        po.spi_oe = 4'hc;
        po.spi_o = 4'h8;
        po.can_en = 1'b1;
        ev[PORT_M] = 8'h01;
        apply(2);
        chk(pad[PORT_M].out & 8'h32, 8'h20);
        chk(pad[PORT_M].oe_n & 8'h0d, 8'h0d);
        chk({7'h00, periph_in.can_rx_line}, 8'h01);
        po = '0;
        wreg(6'h12, 8'h00);
        $display("port s and m test done");
        ev[PORT_AD] = 8'ha5;
        apply(2);
        chk(adc_rb, 8'hf5);
        rchk(6'h21, 8'ha5);
        $display("analog test done");
        // port j rising edge with glitch, port p falling edge
        wreg(6'h2d, 8'h80);
        wreg(6'h2e, 8'h80);
        ev[PORT_J] = 8'h80;
        apply(0);
        ev[PORT_J] = 8'h00;
        apply(20);
        rchk(6'h2f, 8'h00);
        chk({7'h00, irq}, 8'h00);
        ev[PORT_J] = 8'h80;
        apply(20);
        rchk(6'h2f, 8'h80);
        chk({7'h00, irq}, 8'h01);
        wreg(6'h2e, 8'h00);
        settle(2);
        chk({7'h00, irq}, 8'h00);
        wreg(6'h2f, 8'h00);
        rchk(6'h2f, 8'h80);
        wreg(6'h2f, 8'h80);
        rchk(6'h2f, 8'h00);
        wreg(6'h1f, 8'hff);
        wreg(6'h1e, 8'h01);
        ev[PORT_P] = 8'h01;
        apply(20);
        ev[PORT_P] = 8'h00;
        apply(20);
        rchk(6'h1f, 8'h01);
        chk({7'h00, irq}, 8'h01);
        $display("interrupt test done");
        conclude();
    end
endmodule

bind port_pin_function_mux pin_mux_chk #(.TICK_CYC(TICK_CYC), .SAMPLES(SAMPLES)) u_chk (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pad(pad), .periph_out(periph_out), .periph_in(periph_in),
    .adc_digital_input_enable(adc_digital_input_enable),
    .adc_port_readback(adc_port_readback), .irq(irq));
